// *** include/aod_pkg.sv ***
// Package of constants and mode codes for the output demultiplexer block.
package aod_pkg;

  // ----------------------------------------------------------------
  // Widths and codes
  // ----------------------------------------------------------------
  localparam int unsigned SAMPLE_W = 8;
  localparam logic [7:0] CODE_ZERO_SCALE = 8'h00;
  localparam logic [7:0] CODE_FULL_SCALE = 8'hFF;
  localparam logic [7:0] CODE_MID_LOW    = 8'h7F;
  localparam logic [7:0] CODE_MID_HIGH   = 8'h80;
  localparam logic [7:0] RST_WORD        = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_MHZ       = 250;
  localparam int unsigned MAX_SINGLE_MSPS   = 750;
  localparam int unsigned FIFO_DEPTH        = 16;
  localparam int unsigned SYNC_STAGES       = 3;

  // ----------------------------------------------------------------
  // Output modes, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SINGLE_RATE_MODE = 3'b001,
    DUAL_PORT_MODE   = 3'b010,
    DECIMATING_MODE  = 3'b100
  } aod_mode_t;

  // Phase of the output sequencer, one-hot.
  typedef enum logic [1:0] {
    PH_FIRST  = 2'b01,
    PH_SECOND = 2'b10
  } aod_phase_t;

endpackage : aod_pkg

// *** hw/aod_fifo.sv ***
// Parameterised valid/ready FIFO used in the sample path.
`timescale 1ns/1ps
`default_nettype none
module aod_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  // Full when pointers differ only in the wrap bit, empty when equal.
  assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage is written only on an accepted word.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Write pointer.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  // Read pointer.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= rd_q + 1'b1;
    end
  end
endmodule : aod_fifo
`default_nettype wire

// *** hw/aod_top.sv ***
// Output formatter: mode straps, port demultiplexer, data-ready clock and overrange flag.
`timescale 1ns/1ps
`default_nettype none
module aod_top #(
  parameter int unsigned SAMPLE_W   = aod_pkg::SAMPLE_W,
  parameter int unsigned FIFO_DEPTH = aod_pkg::FIFO_DEPTH
) (
  // System clock and reset
  input  wire logic                sys_clk,
  input  wire logic                srst,
  // Sampling clock from the far side, sampled as a plain input
  input  wire logic                sample_clk,
  // Quantiser result for the sample taken on each rising sample-clock edge
  input  wire logic [SAMPLE_W-1:0] quant_code,
  input  wire logic                quant_over,
  // Mode straps
  input  wire logic                split_enable_strap,
  input  wire logic                rate_select_strap,
  input  wire logic                aux_power_strap_a,
  input  wire logic                aux_power_strap_b,
  // Primary port, true and complementary
  output logic [SAMPLE_W-1:0]      primary_port_bits,
  output logic [SAMPLE_W-1:0]      primary_port_bits_n,
  // Auxiliary port, true and complementary
  output logic [SAMPLE_W-1:0]      auxiliary_port_bits,
  output logic [SAMPLE_W-1:0]      auxiliary_port_bits_n,
  // Data-ready clock and overrange flag
  output logic                     data_ready_clock_true,
  output logic                     data_ready_clock_comp,
  output logic                     overrange_true,
  output logic                     overrange_comp,
  // Status
  output logic [2:0]               mode_out,
  output logic                     sample_dropped
);
  localparam int unsigned WORD_W = SAMPLE_W + 1;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned PIN_N = 5;

  logic [PIN_N-1:0]      pin_raw;
  wire logic [PIN_N-1:0] pin_level;
  logic                  clk_level_q;
  logic                  split_q;
  logic                  rate_q;
  logic                  aux_off_q;

  // The sample clock and the four straps, gathered so that one loop
  // builds all of their synchronisers.
  assign pin_raw = {aux_power_strap_b, aux_power_strap_a, rate_select_strap, split_enable_strap, sample_clk};

  // Three synchroniser flops and a level flop per pin; the first is read only by the second. A level is
  // accepted only once the second and third stages agree, which keeps a
  // metastable first stage from ever reaching the logic behind.
  for (genvar gi = 0; gi < PIN_N; gi++) begin : g_pin_sync
    logic [aod_pkg::SYNC_STAGES-1:0] sync_q;
    logic                            level_q;

    always_ff @(posedge sys_clk) begin
      if (srst) begin
        sync_q  <= '0;
        level_q <= 1'b0;
      end else begin
        sync_q <= {sync_q[aod_pkg::SYNC_STAGES-2:0], pin_raw[gi]};
        if (sync_q[aod_pkg::SYNC_STAGES-2] == sync_q[aod_pkg::SYNC_STAGES-1]) begin
          level_q <= sync_q[aod_pkg::SYNC_STAGES-1];
        end
      end
    end

    assign pin_level[gi] = level_q;
  end

  // Named views of the filtered levels, in the order gathered above.
  assign clk_level_q = pin_level[0];
  assign split_q     = pin_level[1];
  assign rate_q      = pin_level[2];

  // The auxiliary drivers go off only while both power straps sit low.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aux_off_q <= 1'b0;
    end else begin
      aux_off_q <= !pin_level[3] && !pin_level[4];
    end
  end

  // ----------------------------------------------------------------
  // Sample capture into the FIFO
  // ----------------------------------------------------------------
  logic                clk_level_d1_q;
  logic                rise;
  logic [SAMPLE_W-1:0] code_q;
  logic                over_q;
  logic                cap_valid_q;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic                fifo_out_ready;
  logic [WORD_W-1:0]   fifo_out_data;

  assign rise = clk_level_q && !clk_level_d1_q;

  // The code bus is stable around the sampling edge, so it is captured on
  // the detected rise; an overranged sample is forced to all ones.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      clk_level_d1_q <= 1'b0;
      code_q         <= aod_pkg::RST_WORD;
      over_q         <= 1'b0;
      cap_valid_q    <= 1'b0;
    end else begin
      clk_level_d1_q <= clk_level_q;
      cap_valid_q    <= rise;
      if (rise) begin
        code_q <= quant_over ? aod_pkg::CODE_FULL_SCALE : quant_code;
        over_q <= quant_over;
      end
    end
  end

  // Only a word refused by a full FIFO is reported. The sample clock is the far side's to keep
  // within the single-rate limit; one that outruns the synchroniser loses
  // rises without any report here.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sample_dropped <= 1'b0;
    end else begin
      sample_dropped <= cap_valid_q && !fifo_in_ready;
    end
  end

  aod_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .in_valid  (cap_valid_q),
    .in_ready  (fifo_in_ready),
    .in_data   ({over_q, code_q}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  aod_pkg::aod_mode_t mode_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_q <= aod_pkg::SINGLE_RATE_MODE;
    end else if (!split_q) begin
      mode_q <= aod_pkg::SINGLE_RATE_MODE;
    end else if (!rate_q) begin
      mode_q <= aod_pkg::DUAL_PORT_MODE;
    end else begin
      mode_q <= aod_pkg::DECIMATING_MODE;
    end
  end

  // ----------------------------------------------------------------
  // Output sequencer
  // ----------------------------------------------------------------
  aod_pkg::aod_phase_t phase_q;
  logic                keep_q;     // Decimation keep/drop toggle.
  logic [WORD_W-1:0]   older_q;    // First sample of a pair.
  logic [WORD_W-1:0]   prev_q;     // Last primary word, for the lagged copy.
  logic [SAMPLE_W-1:0] prim_q;
  logic [SAMPLE_W-1:0] aux_q;
  logic                or_q;
  logic                drdy_q;
  logic                is_single;  // Single-rate mode selected.
  logic                use_word;   // FIFO word taken and not decimated away.
  logic                emit_word;  // A new output word is complete.

  // The sequencer drains one word per cycle; the FIFO absorbs link jitter.
  assign fifo_out_ready = 1'b1;

  // Latency from a detected sample-clock rise: the word is captured, written
  // into the FIFO on the next edge, taken by the sequencer on the edge after
  // that and shown by the output registers one edge later, together with the
  // data-ready rise. In the split modes only the second sample of a pair
  // makes a word, so the older sample waits a whole sample period in the
  // sequencer in dual-port mode and two sample periods in decimating mode.
  assign is_single = (mode_q == aod_pkg::SINGLE_RATE_MODE);
  assign use_word  = fifo_out_valid && ((mode_q != aod_pkg::DECIMATING_MODE) || keep_q);
  assign emit_word = use_word && (is_single || (phase_q == aod_pkg::PH_SECOND));

  // Keep/drop toggle; it only runs in decimating mode and dual-port mode sets it, so a
  // switch from dual-port keeps its first sample, while single-rate holds the toggle.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      keep_q <= 1'b1;
    end else if (fifo_out_valid && !is_single) begin
      keep_q <= (mode_q == aod_pkg::DECIMATING_MODE) ? !keep_q : 1'b1;
    end
  end

  // Pair phase; single-rate holds it at the first slot.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      phase_q <= aod_pkg::PH_FIRST;
    end else if (fifo_out_valid && is_single) begin
      phase_q <= aod_pkg::PH_FIRST;
    end else if (use_word) begin
      case (phase_q)
        aod_pkg::PH_FIRST: begin
          phase_q <= aod_pkg::PH_SECOND;
        end
        default: begin
          phase_q <= aod_pkg::PH_FIRST;
        end
      endcase
    end
  end

  // The older sample of a pair waits here for its partner.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      older_q <= '0;
    end else if (use_word && !is_single && (phase_q == aod_pkg::PH_FIRST)) begin
      older_q <= fifo_out_data;
    end
  end

  // The last single-rate word, which the auxiliary port repeats one sample late.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prev_q <= '0;
    end else if (use_word && is_single) begin
      prev_q <= fifo_out_data;
    end
  end

  // Port words and flag change together, so they always describe one word.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prim_q <= aod_pkg::RST_WORD;
      aux_q  <= aod_pkg::RST_WORD;
      or_q   <= 1'b0;
    end else if (emit_word && is_single) begin
      prim_q <= fifo_out_data[SAMPLE_W-1:0];
      aux_q  <= prev_q[SAMPLE_W-1:0];
      or_q   <= fifo_out_data[SAMPLE_W];
    end else if (emit_word) begin
      aux_q  <= older_q[SAMPLE_W-1:0];
      prim_q <= fifo_out_data[SAMPLE_W-1:0];
      or_q   <= older_q[SAMPLE_W] || fifo_out_data[SAMPLE_W];
    end
  end

  // One data-ready strobe per word shown.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      drdy_q <= 1'b0;
    end else begin
      drdy_q <= emit_word;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Words, flag and data-ready all launch on one clock edge, so the new
  // words arrive with the data-ready rise. The far side latches on that
  // rise and the words then stand until the next one.

  // Primary port, true and complementary.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      primary_port_bits   <= aod_pkg::RST_WORD;
      primary_port_bits_n <= ~aod_pkg::RST_WORD;
    end else begin
      primary_port_bits   <= prim_q;
      primary_port_bits_n <= ~prim_q;
    end
  end

  // Auxiliary port; with its drivers powered down both lines rest high.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      auxiliary_port_bits   <= aod_pkg::RST_WORD;
      auxiliary_port_bits_n <= ~aod_pkg::RST_WORD;
    end else if (aux_off_q) begin
      auxiliary_port_bits   <= {SAMPLE_W{1'b1}};
      auxiliary_port_bits_n <= {SAMPLE_W{1'b1}};
    end else begin
      auxiliary_port_bits   <= aux_q;
      auxiliary_port_bits_n <= ~aux_q;
    end
  end

  // Shared overrange flag, launched with the words it describes.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      overrange_true <= 1'b0;
      overrange_comp <= 1'b1;
    end else begin
      overrange_true <= or_q;
      overrange_comp <= !or_q;
    end
  end

  // Data-ready clock, high for one system-clock cycle per word.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      data_ready_clock_true <= 1'b0;
      data_ready_clock_comp <= 1'b1;
    end else begin
      data_ready_clock_true <= drdy_q;
      data_ready_clock_comp <= !drdy_q;
    end
  end

  // Mode report for the far side.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_out <= aod_pkg::SINGLE_RATE_MODE;
    end else begin
      mode_out <= mode_q;
    end
  end
endmodule : aod_top
`default_nettype wire

// *** tb/aod_top_props.sv ***
// Concurrent checks on the output formatter's ports.
`timescale 1ns/1ps
`default_nettype none
module aod_top_props #(
  parameter int unsigned SAMPLE_W = 8
) (
  // Clock and reset
  input wire logic                sys_clk,
  input wire logic                srst,
  // Straps
  input wire logic                split_enable_strap,
  input wire logic                rate_select_strap,
  input wire logic                aux_power_strap_a,
  input wire logic                aux_power_strap_b,
  // Ports and flags
  input wire logic [SAMPLE_W-1:0] primary_port_bits,
  input wire logic [SAMPLE_W-1:0] primary_port_bits_n,
  input wire logic [SAMPLE_W-1:0] auxiliary_port_bits,
  input wire logic [SAMPLE_W-1:0] auxiliary_port_bits_n,
  input wire logic                data_ready_clock_true,
  input wire logic                data_ready_clock_comp,
  input wire logic                overrange_true,
  input wire logic                overrange_comp,
  input wire logic [2:0]          mode_out
);
  logic [3:0]          calm_q;
  logic [SAMPLE_W-1:0] last_q;
  wire logic           word   = data_ready_clock_true;
  wire logic           calm   = calm_q == 4'hF;
  wire logic           single = mode_out == 3'b001;
  wire logic [2:0]     mode_exp = !split_enable_strap ? 3'b001 : (rate_select_strap ? 3'b100 : 3'b010);

  // Straps take effect a few cycles late through the synchronisers, so words within 15 cycles of a strap change are not judged.
  always_ff @(posedge sys_clk) begin
    if (srst || !$stable({split_enable_strap, rate_select_strap, aux_power_strap_a, aux_power_strap_b})) begin
      calm_q <= 4'h0;
    end else if (!calm) begin
      calm_q <= calm_q + 4'h1;
    end
  end

  // Primary word of the previous output word.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      last_q <= aod_pkg::RST_WORD;
    end else if (word) begin
      last_q <= primary_port_bits;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence one_pulse;
    data_ready_clock_true ##1 !data_ready_clock_true;
  endsequence

  chk_pulse_width: assert property (word |-> one_pulse)
    else $error("data-ready pulse too long");
  chk_ready_comp: assert property (data_ready_clock_comp == !word)
    else $error("data-ready complement wrong");
  chk_port_comp: assert property (
    primary_port_bits_n == ~primary_port_bits && overrange_comp == !overrange_true)
    else $error("complement lines wrong");
  chk_aux_comp: assert property (
    calm && (aux_power_strap_a || aux_power_strap_b) |-> auxiliary_port_bits_n == ~auxiliary_port_bits)
    else $error("aux complement lines wrong");
  chk_word_lead: assert property (
    ($changed(primary_port_bits) || $changed(overrange_true)) |-> word)
    else $error("word changed without data-ready");
  chk_aux_off: assert property (
    word && calm && !aux_power_strap_a && !aux_power_strap_b |-> &{auxiliary_port_bits, auxiliary_port_bits_n})
    else $error("powered-down aux not high");
  chk_mode_code: assert property (word && calm |-> mode_out == mode_exp)
    else $error("mode code wrong");
  chk_single_flag: assert property (word && single && overrange_true |-> &primary_port_bits)
    else $error("single flag without full-scale primary");
  chk_split_flag: assert property (
    word && !single && overrange_true |-> (&primary_port_bits || &auxiliary_port_bits))
    else $error("split flag without full-scale word");
  chk_aux_lag: assert property (
    word && single && calm && (aux_power_strap_a || aux_power_strap_b) |-> auxiliary_port_bits == last_q)
    else $error("aux not one sample behind");
endmodule : aod_top_props
`default_nettype wire

// *** tb/aod_capture.sv ***
// Capture model that latches both output ports on each data-ready pulse.
`timescale 1ns/1ps
`default_nettype none
module aod_capture (
  // Clock
  input  wire logic       sys_clk,
  // Formatter outputs
  input  wire logic [7:0] prim_in,
  input  wire logic [7:0] aux_in,
  input  wire logic       over_in,
  input  wire logic       ready_in,
  // Captured word
  output logic [7:0]      prim_cap,
  output logic [7:0]      aux_cap,
  output logic            over_cap,
  output logic            cap_stb
);
  // Words and flag are taken on one edge, so they can never come from different words.
  always_ff @(posedge sys_clk) begin
    cap_stb <= ready_in;
    if (ready_in) begin
      prim_cap <= prim_in;
      aux_cap  <= aux_in;
      over_cap <= over_in;
    end
  end
endmodule : aod_capture
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the output formatter.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [19:0] CFG = 20'h3_4BF2;
  localparam logic [31:0] BND = 32'hFF80_7F00;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        sample_clk = 1'b0;
  logic [7:0]  quant_code = 8'h00;
  logic        quant_over = 1'b0;
  logic        split_enable_strap = 1'b0, rate_select_strap = 1'b0;
  logic        aux_power_strap_a = 1'b1, aux_power_strap_b = 1'b1;
  logic [7:0]  primary_port_bits, primary_port_bits_n, auxiliary_port_bits, auxiliary_port_bits_n;
  logic        data_ready_clock_true, data_ready_clock_comp, overrange_true, overrange_comp;
  logic        sample_dropped, over_cap, cap_stb, held_or, held;
  logic [2:0]  mode_out;
  logic [7:0]  prim_cap, aux_cap, prev_w, held_w;
  logic [16:0] exp_q[$];
  int          errors = 0, cmp_count = 0, n;

  aod_top uut (.sys_clk, .srst, .sample_clk, .quant_code, .quant_over, .split_enable_strap,
    .rate_select_strap, .aux_power_strap_a, .aux_power_strap_b, .primary_port_bits,
    .primary_port_bits_n, .auxiliary_port_bits, .auxiliary_port_bits_n, .data_ready_clock_true,
    .data_ready_clock_comp, .overrange_true, .overrange_comp, .mode_out, .sample_dropped);
  aod_capture u_cap (.sys_clk, .prim_in(primary_port_bits), .aux_in(auxiliary_port_bits),
    .over_in(overrange_true), .ready_in(data_ready_clock_true), .prim_cap, .aux_cap, .over_cap, .cap_stb);

  // A 4 ns system clock.
  always #2 sys_clk = ~sys_clk;

  task automatic check(input logic ok, input string what);
    cmp_count++;
    if (!ok) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : check

  // Reference model, called once per rising sample-clock edge.
  task automatic take(input logic [7:0] c, input logic o);
    logic [7:0] v;
    v = o ? 8'hFF : c;
    if (!split_enable_strap) begin
      exp_q.push_back({o, (aux_power_strap_a || aux_power_strap_b) ? prev_w : 8'hFF, v});
      prev_w = v;
    end else if (!rate_select_strap || n % 2 == 0) begin
      if (held) begin
        exp_q.push_back({o | held_or, held_w, v});
      end
      held = !held;
      held_w = v;
      held_or = o;
    end
    n++;
  endtask : take

  // Each captured word must be the next one the model predicts.
  always @(negedge sys_clk) begin
    if (srst === 1'b0 && sample_dropped !== 1'b0) begin
      check(1'b0, "sample lost");
    end
    if (cap_stb === 1'b1) begin
      check(exp_q.size() != 0 && sample_dropped !== 1'b1, "unexpected word");
      if (exp_q.size() != 0) begin
        check({over_cap, aux_cap, prim_cap} === exp_q.pop_front(), "captured word");
      end
      check(mode_out === (!split_enable_strap ? 3'b001 : rate_select_strap ? 3'b100 : 3'b010), "mode");
    end
  end

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // Five strap settings, each run from a fresh reset because pairing restarts only there or on a single-rate sample.
  initial begin
    void'($urandom(66394));
    for (int t = 0; t < 5; t++) begin
      @(negedge sys_clk);
      srst = 1'b1;
      {split_enable_strap, rate_select_strap, aux_power_strap_a, aux_power_strap_b} = CFG[4*t +: 4];
      exp_q.delete();
      n = 0;
      held = 1'b0;
      prev_w = 8'h00;
      repeat (4) @(negedge sys_clk);
      check(primary_port_bits === 8'h00 && overrange_true === 1'b0 && mode_out === 3'b001, "reset");
      srst = 1'b0;
      // The 160 ns sample clock stays well under the single-rate limit.
      for (int s = 0; s < 12; s++) begin
        quant_code = (s < 4) ? BND[8*s +: 8] : 8'($urandom);
        quant_over = ($urandom_range(3) == 0);
        repeat (20) @(negedge sys_clk);
        sample_clk = 1'b1;
        take(quant_code, quant_over);
        repeat (20) @(negedge sys_clk);
        sample_clk = 1'b0;
      end
      repeat (30) @(negedge sys_clk);
      check(exp_q.size() == 0, "words missing");
    end
    summarize();
  end

  // Cuts a hang short; the tests need about 10.3 us.
  initial begin
    #50000;
    check(1'b0, "timeout");
    summarize();
  end
endmodule : tb

bind aod_top aod_top_props #(.SAMPLE_W(SAMPLE_W)) u_props (.sys_clk, .srst, .split_enable_strap,
  .rate_select_strap, .aux_power_strap_a, .aux_power_strap_b, .primary_port_bits, .primary_port_bits_n,
  .auxiliary_port_bits, .auxiliary_port_bits_n, .data_ready_clock_true, .data_ready_clock_comp,
  .overrange_true, .overrange_comp, .mode_out);
`default_nettype wire
